// [rtl/sep_cfg.svh]
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

// ==========================================================
// Instruction encoding
`define SEP_OPC_BITS 5'h02
`define SEP_OP_READ 2'b10
`define SEP_OP_ERASE 2'b11
`define SEP_OP_WRITE 2'b01
`define SEP_OP_EXT 2'b00
`define SEP_EXT_ENABLE 2'b11
`define SEP_EXT_DISABLE 2'b00
`define SEP_EXT_CLEAR_ALL 2'b10
`define SEP_EXT_WRITE_ALL 2'b01

// ==========================================================
// Field lengths per organisation
`define SEP_ADDR_BITS_X8 5'h09
`define SEP_ADDR_BITS_X16 5'h08
`define SEP_DATA_BITS_X8 5'h08
`define SEP_DATA_BITS_X16 5'h10
`define SEP_WORD_ADDR_LAST 8'h7f
`define SEP_BYTE_ADDR_LAST 8'hff

// ==========================================================
// Array contents and timing
`define SEP_ERASED_WORD 16'hffff
`define SEP_ERASED_BYTE 8'hff
`define SEP_T_PROG_NS 5000000
`define SEP_CLK_PERIOD_NS 50
`define SEP_FIFO_DEPTH 32

`endif

// [rtl/sep_pkg.sv]
package sep_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_DONE} sep_state_e;
  typedef enum logic [1:0] {PG_WRITE, PG_ERASE, PG_CLEAR_ALL, PG_WRITE_ALL} sep_prog_e;
  typedef struct packed {
    sep_prog_e op;
    logic wide;
    logic [7:0] addr;
    logic [15:0] data;
  } sep_cmd_s;
endpackage

// [rtl/sep_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sep_cfg.svh"

// ==========================================================
// Command queue between the serial decoder and the program engine
module sep_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `SEP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] buf_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = buf_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      buf_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// Function
// - Each instruction opens with start bit 1, then 2-bit opcode, then address.
// - Write and write-all carry 16 data bits, or 8 in byte organisation.
// - Opcode 10 reads, 11 erases, 01 writes one location at full address.
// - Opcode 00 with top address bits 11 enables, 00 disables programming.
// - Opcode 00 with top bits 10 clears all, 01 writes all with data.
// - Selected after a program start, output shows low while busy, high when ready.
// - A 1 shifted in while selected releases the output at that clock rise.
// - Read enables output after last address bit, sends 0, then word MSB first.
// - Read output bits change on the rising shift clock edge.
// - Continued clocking reads the next address, wrapping from last to zero.
// - Only the first word of a sequential read has the leading 0 bit.
// - Programming starts disabled; writes and erases rejected until enabled.
// - Programming stays enabled until reset or a disable instruction.
// - Reads work whether programming is enabled or not.
// - Falling select after a complete program instruction starts the program cycle.
// - The program cycle completes without further shift clock pulses.
// - A word write replaces the old contents without a separate erase.
// - An erase sets every bit of the addressed word to 1.
// - Clear-all sets every bit of the array to 1.
// - Write-all stores its data word into every location.
// - Input bits are sampled at each rising shift clock edge.
// - Output is released unless read data or status is presented.
// - Width select low gives 8-bit words, high gives 16-bit words.
module sep_port #(
  parameter int PROG_CYCLES = `SEP_T_PROG_NS / `SEP_CLK_PERIOD_NS,
  parameter int WORDS = 128
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial pins from the host
  input wire logic select,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic word_width_select,
  // Serial output pin
  output logic serial_out,
  output logic serial_out_oe_b,
  // Status
  output logic prog_busy
);
  import sep_pkg::*;

  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int CW = $bits(sep_cmd_s);

  // ==========================================================
  // Reset release and pin edges
  logic rst_meta_r;
  logic rst_n;
  logic sk_q_r;
  logic sel_q_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sk_q_r <= 1'b0;
      sel_q_r <= 1'b0;
    end else begin
      sk_q_r <= shift_clock;
      sel_q_r <= select;
    end
  end

  logic sk_rise;
  logic sel_fall;
  logic sel_rise;
  assign sk_rise = select && shift_clock && !sk_q_r;
  assign sel_fall = sel_q_r && !select;
  assign sel_rise = !sel_q_r && select;

  // ==========================================================
  // Instruction decoder
  sep_state_e state_r;
  logic [4:0] cnt_r;
  logic wide_r;
  logic [1:0] opc_r;
  logic [8:0] addr_sh_r;
  logic [15:0] data_sh_r;
  logic [8:0] addr_new;
  logic [15:0] data_new;
  logic [1:0] top_bits;
  logic [4:0] abits;
  logic [4:0] dbits;
  logic last_addr;
  logic last_data;
  logic rd_start;
  logic prog_en_r;

  assign addr_new = {addr_sh_r[7:0], serial_in};
  assign data_new = {data_sh_r[14:0], serial_in};
  assign abits = wide_r ? `SEP_ADDR_BITS_X16 : `SEP_ADDR_BITS_X8;
  assign dbits = wide_r ? `SEP_DATA_BITS_X16 : `SEP_DATA_BITS_X8;
  assign top_bits = wide_r ? addr_new[7:6] : addr_new[8:7];
  assign last_addr = sk_rise && (state_r == ST_ADDR) && (cnt_r == abits - 5'h01);
  assign last_data = sk_rise && (state_r == ST_DATA) && (cnt_r == dbits - 5'h01);
  assign rd_start = last_addr && (opc_r == `SEP_OP_READ);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      wide_r <= 1'b1;
      opc_r <= '0;
      addr_sh_r <= '0;
      data_sh_r <= '0;
    end else if (!select) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else if (sk_rise) begin
      case (state_r)
        ST_IDLE: begin
          if (serial_in) begin
            state_r <= ST_OPC;
            wide_r <= word_width_select;
            cnt_r <= '0;
          end
        end
        ST_OPC: begin
          opc_r <= {opc_r[0], serial_in};
          cnt_r <= (cnt_r == `SEP_OPC_BITS - 5'h01) ? '0 : cnt_r + 5'h01;
          if (cnt_r == `SEP_OPC_BITS - 5'h01) begin
            state_r <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          addr_sh_r <= addr_new;
          cnt_r <= cnt_r + 5'h01;
          if (last_addr) begin
            cnt_r <= '0;
            if (opc_r == `SEP_OP_READ) begin
              state_r <= ST_READ;
            end else if (opc_r == `SEP_OP_WRITE) begin
              state_r <= ST_DATA;
            end else if (opc_r == `SEP_OP_EXT && top_bits == `SEP_EXT_WRITE_ALL) begin
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DATA: begin
          data_sh_r <= data_new;
          cnt_r <= cnt_r + 5'h01;
          if (last_data) begin
            state_r <= ST_DONE;
          end
        end
        ST_READ: state_r <= ST_READ;
        ST_DONE: state_r <= ST_DONE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Programming enable latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_en_r <= 1'b0;
    end else if (last_addr && opc_r == `SEP_OP_EXT) begin
      if (top_bits == `SEP_EXT_ENABLE) begin
        prog_en_r <= 1'b1;
      end else if (top_bits == `SEP_EXT_DISABLE) begin
        prog_en_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Completed program instruction, launched by deselect
  sep_cmd_s hold_cmd_r;
  logic hold_r;
  sep_cmd_s pend_cmd_r;
  logic pend_r;
  logic fifo_in_ready;
  logic launch;

  // A command queued behind a full queue stalls here; new ones are then refused.
  assign launch = sel_fall && hold_r && !pend_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
      hold_cmd_r <= '0;
    end else if (!select) begin
      hold_r <= 1'b0;
    end else if (prog_en_r && last_addr && opc_r == `SEP_OP_ERASE) begin
      hold_r <= 1'b1;
      hold_cmd_r <= '{op: PG_ERASE, wide: wide_r, addr: addr_new[7:0], data: '0};
    end else if (prog_en_r && last_addr && opc_r == `SEP_OP_EXT
                 && top_bits == `SEP_EXT_CLEAR_ALL) begin
      hold_r <= 1'b1;
      hold_cmd_r <= '{op: PG_CLEAR_ALL, wide: wide_r, addr: '0, data: '0};
    end else if (prog_en_r && last_data) begin
      hold_r <= 1'b1;
      hold_cmd_r <= '{op: (opc_r == `SEP_OP_WRITE) ? PG_WRITE : PG_WRITE_ALL,
                      wide: wide_r, addr: addr_sh_r[7:0], data: data_new};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      pend_cmd_r <= '0;
    end else if (launch) begin
      pend_r <= 1'b1;
      pend_cmd_r <= hold_cmd_r;
    end else if (fifo_in_ready) begin
      pend_r <= 1'b0;
    end
  end

  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [CW-1:0] fifo_out_data;
  sep_cmd_s eng_cmd;

  sep_fifo #(.W(CW), .DEPTH(`SEP_FIFO_DEPTH)) u_cmd_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(pend_r),
    .in_ready(fifo_in_ready),
    .in_data(pend_cmd_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ==========================================================
  // Self-timed program engine and the array
  logic [15:0] mem_r [WORDS];
  logic eng_active_r;
  logic [TW-1:0] tmr_r;
  sep_cmd_s act_cmd_r;
  logic eng_finish;
  logic busy_w;

  assign eng_cmd = sep_cmd_s'(fifo_out_data);
  assign fifo_out_ready = !eng_active_r;
  assign eng_finish = eng_active_r && (tmr_r == '0);
  assign busy_w = eng_active_r || fifo_out_valid || pend_r;

  // The timer runs on sys_clk alone, so the cycle ends with the host idle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_active_r <= 1'b0;
      tmr_r <= '0;
      act_cmd_r <= '0;
    end else if (!eng_active_r && fifo_out_valid) begin
      eng_active_r <= 1'b1;
      tmr_r <= TW'(PROG_CYCLES - 1);
      act_cmd_r <= eng_cmd;
    end else if (eng_active_r) begin
      tmr_r <= tmr_r - 1'b1;
      if (tmr_r == '0) begin
        eng_active_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= `SEP_ERASED_WORD;
      end
    end else if (eng_finish) begin
      case (act_cmd_r.op)
        PG_WRITE, PG_ERASE: begin
          if (act_cmd_r.wide) begin
            mem_r[act_cmd_r.addr[6:0]] <= (act_cmd_r.op == PG_ERASE)
              ? `SEP_ERASED_WORD : act_cmd_r.data;
          end else if (act_cmd_r.addr[0]) begin
            mem_r[act_cmd_r.addr[7:1]][15:8] <= (act_cmd_r.op == PG_ERASE)
              ? `SEP_ERASED_BYTE : act_cmd_r.data[7:0];
          end else begin
            mem_r[act_cmd_r.addr[7:1]][7:0] <= (act_cmd_r.op == PG_ERASE)
              ? `SEP_ERASED_BYTE : act_cmd_r.data[7:0];
          end
        end
        PG_CLEAR_ALL: begin
          for (int i = 0; i < WORDS; i++) begin
            mem_r[i] <= `SEP_ERASED_WORD;
          end
        end
        PG_WRITE_ALL: begin
          for (int i = 0; i < WORDS; i++) begin
            mem_r[i] <= act_cmd_r.wide ? act_cmd_r.data
              : {act_cmd_r.data[7:0], act_cmd_r.data[7:0]};
          end
        end
        default: mem_r[0] <= mem_r[0];
      endcase
    end
  end

  // ==========================================================
  // Read data path and serial output
  logic [7:0] rd_addr_r;
  logic [15:0] rd_sh_r;
  logic [4:0] rd_cnt_r;
  logic [7:0] rd_last;
  logic [7:0] rd_inc;
  logic rd_next;
  logic stat_pend_r;
  logic stat_show_r;

  function automatic logic [15:0] fetch(input logic [7:0] a, input logic w);
    logic [15:0] word;
    word = mem_r[w ? a[6:0] : a[7:1]];
    if (w) begin
      return word;
    end
    return {(a[0] ? word[15:8] : word[7:0]), 8'h00};
  endfunction

  assign rd_last = wide_r ? `SEP_WORD_ADDR_LAST : `SEP_BYTE_ADDR_LAST;
  assign rd_inc = (rd_addr_r == rd_last) ? 8'h00 : rd_addr_r + 8'h01;
  assign rd_next = sk_rise && (state_r == ST_READ) && (rd_cnt_r == 5'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= '0;
      rd_sh_r <= '0;
      rd_cnt_r <= '0;
    end else if (rd_start) begin
      rd_addr_r <= addr_new[7:0] & rd_last;
      rd_sh_r <= fetch(addr_new[7:0], wide_r);
      rd_cnt_r <= dbits;
    end else if (sk_rise && state_r == ST_READ) begin
      if (rd_next) begin
        rd_addr_r <= rd_inc;
        rd_sh_r <= fetch(rd_inc, wide_r);
        rd_cnt_r <= dbits;
      end else begin
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
        rd_cnt_r <= rd_cnt_r - 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_pend_r <= 1'b0;
      stat_show_r <= 1'b0;
    end else begin
      if (launch) begin
        stat_pend_r <= 1'b1;
      end else if (sel_rise) begin
        stat_pend_r <= 1'b0;
      end
      if (!select) begin
        stat_show_r <= 1'b0;
      end else if (sel_rise && stat_pend_r) begin
        stat_show_r <= 1'b1;
      end else if (sk_rise && serial_in) begin
        stat_show_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b1;
      serial_out_oe_b <= 1'b1;
    end else if (!select) begin
      serial_out_oe_b <= 1'b1;
    end else if (rd_start) begin
      serial_out <= 1'b0;
      serial_out_oe_b <= 1'b0;
    end else if (sk_rise && state_r == ST_READ) begin
      serial_out <= rd_sh_r[15];
    end else if (stat_show_r && !(sk_rise && serial_in)) begin
      serial_out <= !busy_w;
      serial_out_oe_b <= 1'b0;
    end else if (state_r != ST_READ) begin
      serial_out_oe_b <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy <= 1'b0;
    end else begin
      prog_busy <= busy_w;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_deselect_release: assert property (!select |=> serial_out_oe_b)
    else $error("output driven while deselected");
  a_read_dummy: assert property (rd_start |=> (!serial_out_oe_b && !serial_out))
    else $error("read did not start with a driven zero");
  a_launch_enabled: assert property (launch |-> prog_en_r)
    else $error("program command launched while disabled");
  a_status_level: assert property ((stat_show_r && select && !sk_rise && !rd_start)
    |=> (!serial_out_oe_b && serial_out == !$past(busy_w)))
    else $error("status level does not follow busy");
  a_dummy_release: assert property ((stat_show_r && sk_rise && serial_in
    && state_r != ST_READ && !rd_start) |=> serial_out_oe_b)
    else $error("dummy one did not release the output");
  a_read_wrap: assert property ((rd_next && rd_addr_r == rd_last) |=> rd_addr_r == 8'h00)
    else $error("read address failed to wrap");
  a_prog_timer: assert property ($rose(eng_active_r) |-> eng_active_r[*3])
    else $error("program cycle ended too early");
  a_prog_end: assert property (eng_finish |=> !eng_active_r)
    else $error("program cycle did not end at terminal count");
  a_enable_hold: assert property ((prog_en_r && !(last_addr && opc_r == `SEP_OP_EXT))
    |=> prog_en_r)
    else $error("programming enable dropped spontaneously");
  a_erase_ones: assert property ((eng_finish && act_cmd_r.op == PG_ERASE && act_cmd_r.wide)
    |=> mem_r[$past(act_cmd_r.addr[6:0])] == `SEP_ERASED_WORD)
    else $error("erased word not all ones");

  c_read_wrap: cover property (rd_next && rd_addr_r == rd_last);
  c_write_launch: cover property (launch && hold_cmd_r.op == PG_WRITE);
  c_clear_all: cover property (eng_finish && act_cmd_r.op == PG_CLEAR_ALL);
  c_status_poll: cover property (stat_show_r && busy_w ##1 stat_show_r && !busy_w);
endmodule
`default_nettype wire

// [tb/sep_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Host side of the serial link
module sep_host_model (
  // Clock
  input wire logic sys_clk,
  // Pins towards the device
  output logic select,
  output logic shift_clock,
  output logic serial_in,
  // Output pin from the device
  input wire logic serial_out,
  input wire logic serial_out_oe_b
);
  logic last_r;

  initial begin
    select = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
    last_r = 1'b0;
  end

  // Data moves while the clock is low, so it is steady at the rising edge.
  task automatic bit_io(input logic b, output logic so);
    @(posedge sys_clk);
    select <= 1'b1;
    serial_in <= b;
    repeat (2) @(posedge sys_clk);
    shift_clock <= 1'b1;
    repeat (3) @(posedge sys_clk);
    shift_clock <= 1'b0;
    // A released line reads as the inverse of its last level, so it never matches by luck.
    so = serial_out_oe_b ? ~last_r : serial_out;
    last_r = so;
  endtask

  task automatic send(input logic [31:0] v, input int n, output logic so);
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i], so);
    end
  endtask

  task automatic recv(input int n, output logic [15:0] d);
    logic so;
    d = 16'h0000;
    for (int i = 0; i < n; i++) begin
      bit_io(1'b0, so);
      d = {d[14:0], so};
    end
  endtask

  task automatic deselect();
    @(posedge sys_clk);
    select <= 1'b0;
    shift_clock <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic poll();
    @(posedge sys_clk);
    select <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Self-checking bench for the serial command port
module tb;
  localparam int PROG = 12;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic word_width_select = 1'b1;
  logic select;
  logic shift_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_b;
  logic prog_busy;
  int bad_count = 0;
  int tests_run = 0;

  always #25 sys_clk = ~sys_clk;

  sep_host_model host_u (
    .sys_clk(sys_clk),
    .select(select),
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe_b(serial_out_oe_b)
  );

  sep_port #(.PROG_CYCLES(PROG), .WORDS(128)) dut_u (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .select(select),
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .word_width_select(word_width_select),
    .serial_out(serial_out),
    .serial_out_oe_b(serial_out_oe_b),
    .prog_busy(prog_busy)
  );

  // ==========================================================
  // Comparison and reporting
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Instruction builders and shared transfers
  function automatic logic [31:0] wcmd(input logic [1:0] op, input logic [7:0] a,
                                       input logic [15:0] d);
    return {5'h00, 1'b1, op, a, d};
  endfunction

  function automatic logic [31:0] scmd(input logic [1:0] op, input logic [7:0] a);
    return {21'h000000, 1'b1, op, a};
  endfunction

  task automatic read16(input logic [7:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic so;
    logic [15:0] d;
    host_u.send(scmd(2'b10, a), 11, so);
    chk1(so, 1'b0);
    chk1(serial_out_oe_b, 1'b0);
    host_u.recv(16, d);
    chk16(d, e0);
    host_u.recv(16, d);
    chk16(d, e1);
    host_u.deselect();
    chk1(serial_out_oe_b, 1'b1);
  endtask

  // Each program waits out its cycle so that later reads see settled contents.
  task automatic prog(input logic [31:0] v, input int n, input logic busy);
    logic so;
    host_u.send(v, n, so);
    host_u.deselect();
    chk1(prog_busy, busy);
    if (busy) begin
      host_u.poll();
      chk1(serial_out_oe_b, 1'b0);
      chk1(serial_out, 1'b0);
      for (int i = 0; i < 100 && prog_busy !== 1'b0; i++) begin
        @(posedge sys_clk);
      end
      repeat (2) @(posedge sys_clk);
      chk1(prog_busy, 1'b0);
      chk1(serial_out, 1'b1);
      host_u.bit_io(1'b1, so);
      chk1(serial_out_oe_b, 1'b1);
      host_u.deselect();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_locked();
    read16(8'h05, 16'hffff, 16'hffff);
    prog(wcmd(2'b01, 8'h05, 16'h1234), 27, 1'b0);
    read16(8'h05, 16'hffff, 16'hffff);
  endtask

  task automatic t_write();
    prog(scmd(2'b00, 8'hc0), 11, 1'b0);
    prog(wcmd(2'b01, 8'h05, 16'h1234), 27, 1'b1);
    read16(8'h05, 16'h1234, 16'hffff);
    prog(wcmd(2'b01, 8'h05, 16'h00ff), 27, 1'b1);
    read16(8'h04, 16'hffff, 16'h00ff);
    prog(scmd(2'b11, 8'h05), 11, 1'b1);
    read16(8'h05, 16'hffff, 16'hffff);
  endtask

  task automatic t_all();
    prog(wcmd(2'b00, 8'h40, 16'ha5a5), 27, 1'b1);
    prog(wcmd(2'b01, 8'h00, 16'h1234), 27, 1'b1);
    read16(8'h7f, 16'ha5a5, 16'h1234);
    prog(scmd(2'b00, 8'h80), 11, 1'b1);
    read16(8'h7f, 16'hffff, 16'hffff);
  endtask

  task automatic t_byte();
    logic so;
    logic [15:0] d;
    word_width_select <= 1'b0;
    prog({12'h000, 1'b1, 2'b01, 9'h00b, 8'h3c}, 20, 1'b1);
    host_u.send({20'h00000, 1'b1, 2'b10, 9'h00b}, 12, so);
    chk1(so, 1'b0);
    host_u.recv(8, d);
    chk16(d, 16'h003c);
    host_u.recv(8, d);
    chk16(d, 16'h00ff);
    host_u.deselect();
    prog({12'h000, 1'b1, 2'b01, 9'h00a, 8'h5a}, 20, 1'b1);
    word_width_select <= 1'b1;
    read16(8'h05, 16'h3c5a, 16'hffff);
  endtask

  task automatic t_disable();
    prog(scmd(2'b00, 8'h00), 11, 1'b0);
    prog(wcmd(2'b01, 8'h03, 16'h1234), 27, 1'b0);
    read16(8'h03, 16'hffff, 16'hffff);
    prog(scmd(2'b00, 8'h80), 11, 1'b0);
    read16(8'h03, 16'hffff, 16'hffff);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk1(serial_out_oe_b, 1'b1);
    chk1(prog_busy, 1'b0);
    t_locked();
    t_write();
    t_all();
    t_byte();
    t_disable();
    summarize();
  end

  // The full run needs roughly a quarter of this span.
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
